// >>> verilog/prm_ctl.sv
`include "prm_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module prm_ctl
  import prm_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // CPU core
  input  wire prm_cpu_t    cpu,
  input  wire logic [7:0]  interrupt_enable_bit,
  // Pins
  input  wire logic [7:0]  fast_interrupt_pin,
  input  wire logic        nmi_pin_n,
  input  wire logic        reset_input_pin_n,
  input  wire logic        wake_delay_below,
  // Power control
  output logic             cpu_halt,
  output logic             periph_halt,
  output logic             osc_run,
  output logic             delay_pulldown,
  output logic             delay_pullup,
  output logic             resume,
  output logic             refused,
  output logic [7:0]       wake_irq,
  output logic [7:0]       interrupt_request_flag
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic hit(input logic [15:0] a,
                               input logic [15:0] o);
    hit = (a == o);
  endfunction : hit

  function automatic logic pin_idle(input logic [1:0] es,
                                    input logic lvl);
    case (es)
      `PRM_ES_RISE: pin_idle = !lvl;
      `PRM_ES_FALL: pin_idle = lvl;
      default:      pin_idle = 1'b1;
    endcase
  endfunction : pin_idle

  function automatic logic pin_wake(input logic [1:0] es,
                                    input logic lvl,
                                    input logic ref_lvl);
    case (es)
      `PRM_ES_RISE: pin_wake = lvl;
      `PRM_ES_FALL: pin_wake = !lvl;
      `PRM_ES_ANY:  pin_wake = lvl ^ ref_lvl;
      default:      pin_wake = 1'b0;
    endcase
  endfunction : pin_wake

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Bits: 7..0 fast pins, 8 nmi, 9 reset pin, 10 delay
  logic [10:0] s1_q, s2_q, s3_q, f_q;
  wire  [10:0] raw = {wake_delay_below, reset_input_pin_n,
                      nmi_pin_n, fast_interrupt_pin};
  wire  [10:0] agree = ~(s2_q ^ s3_q);
  wire  [10:0] f_d = (agree & s3_q) | (~agree & f_q);

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q <= 11'h600;
      s2_q <= 11'h600;
      s3_q <= 11'h600;
      f_q  <= 11'h600;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= f_d;
    end
  end

  wire [7:0] pin_f  = f_q[7:0];
  wire       nmi_lo = !f_q[8];
  wire       rpin_n = f_q[9];
  wire       dly_f  = f_q[10];

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] edge_q, cfg_q;
  logic [7:0]  wsrc_q;
  wire  wr_go = psel & penable & pready & pwrite;
  wire  rd_en = psel & !penable;
  wire  h_edge = hit(paddr, `PRM_EDGE_OFS);
  wire  h_cfg  = hit(paddr, `PRM_CFG_OFS);
  wire  h_stat = hit(paddr, `PRM_STAT_OFS);
  wire  h_wsrc = hit(paddr, `PRM_WSRC_OFS);
  wire  h_any  = h_edge | h_cfg | h_stat | h_wsrc;
  wire  var_int = cfg_q[`PRM_CFG_VAR];

  prm_state_t st_q, st_d;
  logic        deep_q;
  logic [7:0]  ref_q;

  wire [31:0] stat_w = {17'h0, dly_f, rpin_n, nmi_lo,
                        pin_f, 1'b0, st_q};
  wire [31:0] rd_w = h_edge ? {16'h0, edge_q} :
                     h_cfg  ? {16'h0, cfg_q}  :
                     h_stat ? stat_w :
                     h_wsrc ? {24'h0, wsrc_q} : 32'h0;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= rd_en;
      pslverr <= rd_en & !h_any;
      prdata  <= (rd_en & !pwrite) ? rd_w : 32'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      edge_q <= `PRM_EDGE_RST;
      cfg_q  <= `PRM_CFG_RST;
    end else if (wr_go) begin
      if (h_edge)
        edge_q <= pwdata[15:0];
      if (h_cfg)
        cfg_q  <= pwdata[15:0];
    end
  end

  // ****************************************
  // Per-pin deep sleep checks
  // ****************************************
  wire  [7:0] idle_w, wake_w;
  wire  [7:0] rise_m, fall_m, any_m;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      wire [1:0] es = edge_q[2*gi+1:2*gi];
      assign idle_w[gi] = pin_idle(es, pin_f[gi]);
      assign wake_w[gi] = pin_wake(es, pin_f[gi], ref_q[gi]);
      assign rise_m[gi] = (es == `PRM_ES_RISE);
      assign fall_m[gi] = (es == `PRM_ES_FALL);
      assign any_m[gi]  = (es == `PRM_ES_ANY);
    end
  endgenerate

  wire all_idle = &idle_w;
  wire any_wake = |wake_w;

  // ****************************************
  // Mode sequencer
  // ****************************************
  wire rdy_bad  = cpu.rdy_en & !cpu.rdy_seen;
  wire deep_ok  = var_int ? all_idle : nmi_lo;
  wire drain_ok = cpu.bus_idle & !rdy_bad;
  wire refuse_w = (st_q == ST_DRAIN) & cpu.bus_idle &
                  (rdy_bad | (deep_q & !deep_ok));
  logic wake_go;

  always_comb begin
    st_d    = st_q;
    wake_go = 1'b0;
    case (st_q)
      ST_RUN: begin
        if (cpu.sleep_req | cpu.deep_req)
          st_d = ST_DRAIN;
      end
      ST_DRAIN: begin
        // Stays here while the bus is busy
        if (refuse_w)
          st_d = ST_RUN;
        else if (drain_ok & !deep_q)
          st_d = ST_LIGHT;
        else if (drain_ok)
          st_d = var_int ? ST_DEEP_INT : ST_DEEP_PROT;
      end
      ST_LIGHT: begin
        if (cpu.int_req | cpu.pec_fail)
          st_d = ST_RUN;
      end
      ST_DEEP_PROT: begin
        if (!rpin_n)
          st_d = ST_RUN;
      end
      ST_DEEP_INT: begin
        if (!rpin_n)
          st_d = ST_RUN;
        else if (any_wake) begin
          st_d    = ST_WAKE;
          wake_go = 1'b1;
        end
      end
      ST_WAKE: begin
        if (!rpin_n | dly_f)
          st_d = ST_RUN;
      end
      default: st_d = ST_RUN;
    endcase
  end

  wire halt_d  = !(st_d == ST_RUN || st_d == ST_DRAIN);
  wire deep_d  = (st_d == ST_DEEP_PROT) || (st_d == ST_DEEP_INT);
  wire wake_d  = (st_d == ST_WAKE);
  wire done_w  = (st_q != ST_RUN) && (st_q != ST_DRAIN) &&
                 (st_d == ST_RUN) && rpin_n;
  // Enabled wake sources pulse their service one cycle after resume
  logic [7:0] pend_q;
  wire  [7:0] wsrc_clr = (wr_go & h_wsrc) ? pwdata[7:0] : 8'h00;
  wire  [7:0] wsrc_set = wake_go ? wake_w : 8'h00;

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q   <= ST_RUN;
      deep_q <= 1'b0;
      ref_q  <= 8'h00;
      wsrc_q <= 8'h00;
      pend_q <= 8'h00;
    end else begin
      st_q   <= st_d;
      if (st_q == ST_RUN)
        deep_q <= cpu.deep_req & !cpu.sleep_req;
      if (st_d == ST_DEEP_INT && st_q != ST_DEEP_INT)
        ref_q <= pin_f;
      wsrc_q <= (wsrc_q & ~wsrc_clr) | wsrc_set;
      if (wake_go)
        pend_q <= wake_w & interrupt_enable_bit;
      else if (!halt_d && st_q == ST_RUN)
        pend_q <= 8'h00;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      cpu_halt       <= 1'b0;
      periph_halt    <= 1'b0;
      osc_run        <= 1'b1;
      delay_pulldown <= 1'b0;
      delay_pullup   <= 1'b0;
      resume         <= 1'b0;
      refused        <= 1'b0;
      wake_irq       <= 8'h00;
      interrupt_request_flag <= 8'h00;
    end else begin
      cpu_halt       <= halt_d;
      periph_halt    <= deep_d | wake_d;
      osc_run        <= !deep_d;
      delay_pulldown <= wake_d | !rpin_n;
      // Pull-up off while the pull-down discharges the node
      delay_pullup   <= var_int & !wake_d & rpin_n;
      resume         <= done_w;
      refused        <= refuse_w;
      wake_irq       <= (resume && st_q == ST_RUN) ? pend_q : 8'h00;
      interrupt_request_flag <= (wsrc_q & ~wsrc_clr) | wsrc_set;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_entry_cause: assert property (
    $rose(cpu_halt) |-> $past(st_q) == ST_DRAIN)
    else $error("low-power entry without instruction");
  a_light_periph: assert property (
    st_q == ST_LIGHT |-> cpu_halt && !periph_halt && osc_run)
    else $error("light sleep stopped peripherals");
  a_drain_wait: assert property (
    st_q == ST_DRAIN && !cpu.bus_idle |=> st_q == ST_DRAIN)
    else $error("entry before bus idle");
  a_ready_refuse: assert property (
    st_q == ST_DRAIN && cpu.bus_idle && rdy_bad
      |=> st_q == ST_RUN && refused)
    else $error("entry despite missing ready");
  a_light_exit: assert property (
    st_q == ST_LIGHT && cpu.int_req |=> st_q == ST_RUN && resume)
    else $error("interrupt did not end light sleep");
  a_pec_stay: assert property (
    st_q == ST_LIGHT && cpu.pec_ok && !cpu.pec_fail && !cpu.int_req
      |=> st_q == ST_LIGHT)
    else $error("event transfer ended light sleep");
  a_deep_clock: assert property (
    st_q == ST_DEEP_PROT || st_q == ST_DEEP_INT
      |-> !osc_run && periph_halt && cpu_halt)
    else $error("deep sleep left clock running");
  a_prot_hold: assert property (
    st_q == ST_DEEP_PROT && rpin_n |=> st_q == ST_DEEP_PROT)
    else $error("protected variant left without reset");
  a_wake_gate: assert property (
    st_q == ST_WAKE && rpin_n && !dly_f |=> cpu_halt && delay_pulldown)
    else $error("clocks released before threshold");
  a_irq_order: assert property (
    wake_irq != 8'h00 |-> $past(resume) && !cpu_halt)
    else $error("service call before next instruction");

  // Active pins restated from the field codes, apart from the helper functions
  wire [7:0] act_m = (rise_m & pin_f) | (fall_m & ~pin_f) | (any_m & (pin_f ^ ref_q));

  a_prot_select: assert property (
    st_q == ST_DEEP_PROT && $past(st_q) == ST_DRAIN |-> !$past(var_int))
    else $error("protected variant with variant bit set");
  a_nmi_entry: assert property (
    st_q == ST_DEEP_PROT && $past(st_q) == ST_DRAIN |-> $past(nmi_lo))
    else $error("protected variant entered with nmi high");
  a_int_select: assert property (
    st_q == ST_DEEP_INT && $past(st_q) == ST_DRAIN |-> $past(var_int))
    else $error("interruptible variant with variant bit clear");
  a_pin_entry: assert property (
    st_q == ST_DEEP_INT && $past(st_q) == ST_DRAIN |-> $past((rise_m & pin_f) | (fall_m & ~pin_f)) == 8'h00)
    else $error("deep sleep entered with a fast pin active");
  a_pin_wake: assert property (
    st_q == ST_DEEP_INT && rpin_n && act_m != 8'h00 |=> st_q == ST_WAKE)
    else $error("fast pin request did not wake");
  a_pin_ignore: assert property (
    st_q == ST_DEEP_INT && rpin_n && act_m == 8'h00 |=> st_q == ST_DEEP_INT)
    else $error("deep sleep left without pin request");
  a_reset_exit: assert property (
    (st_q == ST_DEEP_PROT || st_q == ST_DEEP_INT || st_q == ST_WAKE) && !rpin_n
      |=> st_q == ST_RUN && !resume)
    else $error("reset pin did not end deep sleep");
  a_edge_write: assert property (
    wr_go && h_edge |=> edge_q == $past(pwdata[15:0]))
    else $error("edge select write lost");
  a_flag_sticky: assert property (
    !(wr_go && h_wsrc) |=> (wsrc_q & $past(wsrc_q)) == $past(wsrc_q))
    else $error("wake flag cleared without software");
  a_wake_flag: assert property (
    wake_go |=> (wsrc_q & $past(wake_w)) == $past(wake_w))
    else $error("wake source flag not set");
  a_pullup_on: assert property (
    st_q == ST_RUN && var_int && rpin_n |=> delay_pullup)
    else $error("delay pull-up off with variant bit set");
endmodule : prm_ctl
`default_nettype wire

// >>> verilog/prm_regs.svh
`ifndef PRM_REGS_SVH
`define PRM_REGS_SVH
// ****************************************
// Register map (byte addresses)
// ****************************************
`define PRM_EDGE_OFS   16'hf1c0
`define PRM_CFG_OFS    16'hf1c4
`define PRM_STAT_OFS   16'hf1c8
`define PRM_WSRC_OFS   16'hf1cc
`define PRM_EDGE_RST   16'h0000
`define PRM_CFG_RST    16'h0000
`define PRM_CFG_VAR    5
`define PRM_CFG_W      16
// ****************************************
// Edge select field codes
// ****************************************
`define PRM_ES_OFF     2'h0
`define PRM_ES_RISE    2'h1
`define PRM_ES_FALL    2'h2
`define PRM_ES_ANY     2'h3
// ****************************************
// Timing
// ****************************************
`define PRM_MCLK_MHZ   20
`define PRM_WAKE_NS    40
`define PRM_WAKE_CYC   ((`PRM_WAKE_NS * `PRM_MCLK_MHZ + 999) / 1000)
`endif

// >>> verilog/prm_pkg.sv
`default_nettype none
package prm_pkg;
  typedef enum logic [2:0] {
    ST_RUN, ST_DRAIN, ST_LIGHT, ST_DEEP_PROT, ST_DEEP_INT, ST_WAKE
  } prm_state_t;

  // Requests and status from the CPU core
  typedef struct packed {
    logic sleep_req;
    logic deep_req;
    logic int_req;
    logic pec_ok;
    logic pec_fail;
    logic bus_idle;
    logic rdy_en;
    logic rdy_seen;
  } prm_cpu_t;
endpackage : prm_pkg
`default_nettype wire

// >>> sim/prm_far.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// External RC delay node on the wake pin
// ****************************************
module prm_far #(
  parameter int DIS_CYC = 6
) (
  // Clock
  input  wire logic mclk,
  // Pad controls from the device
  input  wire logic delay_pulldown,
  input  wire logic delay_pullup,
  // Threshold comparator
  output logic      wake_delay_below
);
  // Charge in cycles; empty as at power-on. Charging is instant, only discharge is timed
  int unsigned lvl = 0;

  always @(posedge mclk) begin
    if (delay_pullup) begin
      lvl <= DIS_CYC;
    end else if (delay_pulldown && lvl != 0) begin
      lvl <= lvl - 1;
    end
  end

  assign wake_delay_below = (lvl == 0);
endmodule : prm_far
`default_nettype wire

// >>> sim/power_reduction_mode_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "prm_regs.svh"
module power_reduction_mode_control_tb_top
  import prm_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata;
  logic        pready, pslverr;
  prm_cpu_t    cpu = prm_cpu_t'(8'h04);
  logic [7:0]  interrupt_enable_bit = 8'h00;
  logic [7:0]  fast_interrupt_pin = 8'h00;
  logic        nmi_pin_n = 1'b1;
  logic        reset_input_pin_n = 1'b1;
  logic        wake_delay_below;
  logic        cpu_halt, periph_halt, osc_run, delay_pulldown, delay_pullup, resume, refused;
  logic [7:0]  wake_irq, interrupt_request_flag;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cyc = 0;

  always #25 mclk = ~mclk;

  prm_ctl i_prm_ctl (
    .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cpu, .interrupt_enable_bit, .fast_interrupt_pin, .nmi_pin_n, .reset_input_pin_n,
    .wake_delay_below, .cpu_halt, .periph_halt, .osc_run, .delay_pulldown, .delay_pullup,
    .resume, .refused, .wake_irq, .interrupt_request_flag
  );

  prm_far i_prm_far (.mclk, .delay_pulldown, .delay_pullup, .wake_delay_below);

  // ****************************************
  // Tasks
  // ****************************************
  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Bounded wait, sampled mid-cycle so one-cycle pulses are seen
  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 100 && s !== 1'b1; i++) @(negedge mclk);
    chk(32'(s), 32'h1);
  endtask : wait_hi

  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    rdata = prdata;
    chk(32'(pslverr), 32'(a > `PRM_WSRC_OFS));
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task pulse(input logic [7:0] m);
    @(posedge mclk);
    cpu <= prm_cpu_t'(cpu | m);
    @(posedge mclk);
    cpu <= prm_cpu_t'(cpu & ~m);
  endtask : pulse

  // Deep sleep entry, then wake by pin p leaving its idle level
  task wake(input int p, input logic [1:0] es, input logic lvl, input logic [7:0] en);
    apb(1'b1, `PRM_EDGE_OFS, 32'(es) << (2 * p));
    fast_interrupt_pin[p] <= lvl;
    interrupt_enable_bit  <= en;
    repeat (4) @(posedge mclk);
    pulse(8'h40);
    wait_hi(periph_halt);
    chk(32'(cpu_halt), 32'h1);
    @(posedge mclk);
    fast_interrupt_pin[p] <= ~lvl;
    wait_hi(delay_pulldown);
    chk(32'({cpu_halt, osc_run}), 32'h3);
    wait_hi(resume);
    @(negedge mclk);
    chk(32'(wake_irq), 32'(en));
    chk(32'(interrupt_request_flag), 32'h1 << p);
    apb(1'b0, `PRM_WSRC_OFS, 32'h0);
    chk(rdata, 32'h1 << p);
    apb(1'b1, `PRM_WSRC_OFS, 32'hff);
    apb(1'b0, `PRM_WSRC_OFS, 32'h0);
    chk(rdata, 32'h0);
  endtask : wake

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("mismatch at %0t: run too long", $time);
      stop_test;
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, `PRM_EDGE_OFS, 32'h0);
    chk(rdata, 32'h0);
    apb(1'b1, `PRM_EDGE_OFS, 32'hffff_a5c3);
    apb(1'b0, `PRM_EDGE_OFS, 32'h0);
    chk(rdata, 32'h0000_a5c3);
    apb(1'b0, 16'hf1d0, 32'h0);
    chk(32'(cpu_halt), 32'h0);
    $display("test registers done");
    cpu <= prm_cpu_t'(8'h00);
    pulse(8'h80);
    repeat (5) @(negedge mclk);
    chk(32'(cpu_halt), 32'h0);
    @(posedge mclk);
    cpu <= prm_cpu_t'(8'h04);
    wait_hi(cpu_halt);
    chk(32'(periph_halt), 32'h0);
    pulse(8'h10);
    repeat (3) @(negedge mclk);
    chk(32'(cpu_halt), 32'h1);
    pulse(8'h08);
    wait_hi(resume);
    pulse(8'h80);
    wait_hi(cpu_halt);
    pulse(8'h20);
    wait_hi(resume);
    @(posedge mclk);
    cpu <= prm_cpu_t'(8'h06);
    pulse(8'h80);
    wait_hi(refused);
    chk(32'(cpu_halt), 32'h0);
    @(posedge mclk);
    cpu <= prm_cpu_t'(8'h04);
    $display("test light sleep done");
    apb(1'b1, `PRM_CFG_OFS, 32'h20);
    repeat (4) @(negedge mclk);
    chk(32'(delay_pullup), 32'h1);
    wake(0, `PRM_ES_RISE, 1'b0, 8'h00);
    pulse(8'h40);
    wait_hi(refused);
    wake(1, `PRM_ES_FALL, 1'b1, 8'h02);
    $display("test interruptible done");
    apb(1'b1, `PRM_CFG_OFS, 32'h0);
    pulse(8'h40);
    wait_hi(refused);
    @(posedge mclk);
    nmi_pin_n <= 1'b0;
    repeat (4) @(posedge mclk);
    pulse(8'h40);
    wait_hi(periph_halt);
    @(posedge mclk);
    fast_interrupt_pin[1] <= 1'b1;
    repeat (6) @(posedge mclk);
    fast_interrupt_pin[1] <= 1'b0;
    repeat (8) @(negedge mclk);
    chk(32'(cpu_halt), 32'h1);
    @(posedge mclk);
    reset_input_pin_n <= 1'b0;
    repeat (8) @(negedge mclk);
    chk(32'({cpu_halt, periph_halt, resume}), 32'h0);
    @(posedge mclk);
    reset_input_pin_n <= 1'b1;
    $display("test protected done");
    stop_test;
  end
endmodule : power_reduction_mode_control_tb_top
`default_nettype wire
